/* common/adcseq_regs.vh */
/*
 * register map, field positions, reset values and timing counts of the
 * conversion sequencer. assumes inclusion by bare name from verilog/.
 */
`ifndef ADCSEQ_REGS_VH
`define ADCSEQ_REGS_VH

// ==========================================================
// offsets
`define ADCSEQ_OFS_CONTROL   4'h0
`define ADCSEQ_OFS_CONFIG    4'h1
`define ADCSEQ_OFS_RES_HIGH  4'h2
`define ADCSEQ_OFS_RES_LOW   4'h3
`define ADCSEQ_OFS_STATUS    4'h4
`define ADCSEQ_ADDR_W        4

// ==========================================================
// control register fields
`define ADCSEQ_CTL_ENABLE    0
`define ADCSEQ_CTL_GO        1
`define ADCSEQ_CTL_CHS_LO    2
`define ADCSEQ_CTL_CHS_HI    6
`define ADCSEQ_CTL_RESET     8'h00

// ==========================================================
// config register fields
`define ADCSEQ_CFG_IRQ_EN    0
`define ADCSEQ_CFG_CLK_LO    4
`define ADCSEQ_CFG_CLK_HI    6
`define ADCSEQ_CFG_JUSTIFY   7
`define ADCSEQ_CFG_RESET     8'h00
`define ADCSEQ_CLK_RC        2'h3

// ==========================================================
// status register fields
`define ADCSEQ_STS_DONE_FLAG 0
`define ADCSEQ_STS_POWERED   1
`define ADCSEQ_STS_WAKE      2

// ==========================================================
// channel codes
`define ADCSEQ_CHS_LAST_AN   5'h0b
`define ADCSEQ_CHS_NONE      5'h0c
`define ADCSEQ_CHS_TEMP      5'h1d
`define ADCSEQ_CHS_DAC       5'h1e
`define ADCSEQ_CHS_FVR       5'h1f

// ==========================================================
// timing: 11.5 bit periods per conversion, counted in half periods
`define ADCSEQ_HALF_PERIODS  23
`define ADCSEQ_BITS          10
`define ADCSEQ_RC_DELAY_CYC  4
`define ADCSEQ_DIV_DEFAULT   8

`endif

/* tb/adcseq_asserts.sv */
/* port checker of the conversion sequencer.
   assumes binding onto adcseq_top, a single clk_sys domain. */
`timescale 1ns/10ps
module adcseq_checker (
    input wire       clk_sys,
    input wire       reset,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       sleep_mode,
    input wire       special_trigger,
    input wire [4:0] input_channel_select,
    input wire       sample_hold,
    input wire       first_timer_clear,
    input wire       conversion_done_irq_flag,
    input wire       wake_request
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // ==========================================================
    // properties
    AST_TMR_CLR: assert property (special_trigger |=> first_timer_clear)
        else $error("timer clear missing after trigger");
    AST_TMR_CAUSE: assert property (first_timer_clear |-> $past(special_trigger))
        else $error("timer clear without trigger");
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read answer");
    AST_BIT7_ZERO: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata[7] == 1'b0)
        else $error("control bit 7 not zero");
    AST_CHS_LOAD: assert property (reg_wr && reg_addr == 4'h0 |=>
        input_channel_select == $past(reg_wdata[6:2]))
        else $error("channel select not loaded");
    AST_FLAG_SET: assert property ($rose(conversion_done_irq_flag) |-> $past(sample_hold))
        else $error("done flag without conversion");
    AST_FLAG_HOLD: assert property ($fell(conversion_done_irq_flag) |->
        $past(reg_wr) && $past(reg_addr) == 4'h4 && $past(reg_wdata[0]))
        else $error("done flag cleared by hardware");
    AST_WAKE_SLEEP: assert property (wake_request |-> $past(sleep_mode))
        else $error("wake outside sleep");
    AST_WAKE_PULSE: assert property (wake_request |=> !wake_request)
        else $error("wake longer than one cycle");
endmodule // adcseq_checker

bind adcseq_top adcseq_checker adcseq_checker_inst (.clk_sys, .reset, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_mode, .special_trigger,
    .input_channel_select, .sample_hold, .first_timer_clear,
    .conversion_done_irq_flag, .wake_request);

/* tb/adcseq_tb_top.sv */
/* self-checking bench of the conversion sequencer.
   assumes an ideal comparator modelled from the trial code. */
`timescale 1ns/10ps
module adcseq_tb_top;
    reg        clk_sys, reset, reg_wr, reg_rd, sleep_mode, special_trigger, woke;
    reg  [3:0] reg_addr;
    reg  [7:0] reg_wdata, rd_val, got;
    reg  [9:0] target;
    reg [15:0] lfsr, fmt_v;
    reg  [4:0] ch;
    wire [7:0] reg_rdata;
    wire [4:0] input_channel_select;
    wire [9:0] trial_code;
    wire       analog_power, sample_hold, first_timer_clear;
    wire       conversion_done_irq_flag, wake_request;
    wire       comparator_high = (trial_code <= target);
    integer    n_mismatch, cmp_count, i, k;

    adcseq_top adcseq_top_inst (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sleep_mode(sleep_mode), .special_trigger(special_trigger),
        .comparator_high(comparator_high), .analog_power(analog_power),
        .input_channel_select(input_channel_select), .trial_code(trial_code),
        .sample_hold(sample_hold), .first_timer_clear(first_timer_clear),
        .conversion_done_irq_flag(conversion_done_irq_flag), .wake_request(wake_request));

    function [15:0] nxt(input [15:0] s);
        nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function [15:0] fmt(input jr, input [9:0] r);
        fmt = jr ? {6'h00, r} : {r, 6'h00};
    endfunction
    task close_out;
        begin
            $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
            if (n_mismatch == 0 && cmp_count > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task check(input [8*12-1:0] what, input [7:0] exp, input [7:0] got_v);
        begin
            cmp_count = cmp_count + 1;
            if (got_v !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("unexpected %0s expected %h seen %h", what, exp, got_v);
            end
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        begin
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk_sys);
            reg_wr <= 1'b0;
            @(posedge clk_sys);
        end
    endtask
    task rd(input [3:0] a);
        begin
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge clk_sys);
            reg_rd <= 1'b0;
            #1 rd_val = reg_rdata;
            @(posedge clk_sys);
        end
    endtask
    task rchk(input [3:0] a, input [7:0] exp);
        begin
            rd(a);
            check("register", exp, rd_val);
        end
    endtask
    task conv(input [2:0] cs, input jr, input irq, input [4:0] c, input [9:0] t);
        begin
            target <= t;
            wr(4'h1, {jr, cs, 3'h0, irq});
            wr(4'h0, {1'b1, c, 2'b01});
            wr(4'h0, {1'b0, c, 2'b11});
        end
    endtask
    task wait_done;
        begin
            k = 0;
            rd(4'h0);
            while (rd_val[1] === 1'b1 && k < 600) begin
                rd(4'h0);
                k = k + 1;
            end
            if (k >= 600) begin
                n_mismatch = n_mismatch + 1;
                $display("unexpected go still set expected 0 seen 1");
            end
        end
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
        if (wake_request === 1'b1)
            woke <= 1'b1;
    initial begin
        repeat (40000) @(posedge clk_sys);
        n_mismatch = n_mismatch + 1;
        close_out;
    end
    initial begin
        reset = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00;
        sleep_mode = 1'b0; special_trigger = 1'b0; woke = 1'b0; target = 10'h000;
        lfsr = 16'hf720; n_mismatch = 0; cmp_count = 0;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        rchk(4'h0, 8'h00);
        rchk(4'h5, 8'h00);
        wr(4'h0, 8'h02);
        rchk(4'h0, 8'h00);
        // ==========================================================
        // random conversions, every special channel code
        for (i = 0; i < 8; i = i + 1) begin
            lfsr = nxt(lfsr);
            ch = (i == 0) ? 5'h0c : (i < 4) ? 5'h1c + i[4:0]
                 : (lfsr[3:0] > 4'hb) ? 5'h0b : {1'b0, lfsr[3:0]};
            conv(lfsr[6:4], i[0], 1'b0, ch, lfsr[15:6]);
            wait_done;
            fmt_v = fmt(i[0], target);
            check("irq flag", 8'h01, {7'h00, conversion_done_irq_flag});
            check("channel", {3'h0, ch}, {3'h0, input_channel_select});
            rchk(4'h0, {1'b0, ch, 2'b01});
            rchk(4'h2, fmt_v[15:8]);
            rchk(4'h3, fmt_v[7:0]);
            wr(4'h4, 8'h01);
        end
        // ==========================================================
        // abort mid-conversion, fill with last resolved bit
        for (i = 0; i < 2; i = i + 1) begin
            conv(3'b010, 1'b0, 1'b0, 5'h00, i[0] ? 10'h000 : 10'h3ff);
            repeat (150) @(posedge clk_sys);
            wr(4'h0, 8'h01);
            fmt_v = fmt(1'b0, target);
            check("abort flag", 8'h00, {7'h00, conversion_done_irq_flag});
            rchk(4'h2, fmt_v[15:8]);
            rchk(4'h3, fmt_v[7:0]);
        end
        // ==========================================================
        // hardware trigger, enabled then disabled
        target <= 10'h2c3;
        special_trigger <= 1'b1;
        @(posedge clk_sys);
        special_trigger <= 1'b0;
        wait_done;
        check("trig flag", 8'h01, {7'h00, conversion_done_irq_flag});
        rchk(4'h2, 8'hb0);
        wr(4'h4, 8'h01);
        wr(4'h0, 8'h00);
        special_trigger <= 1'b1;
        @(posedge clk_sys);
        special_trigger <= 1'b0;
        rchk(4'h0, 8'h00);
        // ==========================================================
        // sleep: other clock aborts, rc with and without irq enable
        for (i = 0; i < 3; i = i + 1) begin
            woke <= 1'b0;
            conv((i == 0) ? 3'b010 : 3'b011, 1'b0, i == 1, 5'h01, 10'h155);
            sleep_mode <= 1'b1;
            repeat (700) @(posedge clk_sys);
            got = {5'h00, analog_power & (i != 1), conversion_done_irq_flag, woke};
            check("sleep", (i == 0) ? 8'h00 : (i == 1) ? 8'h03 : 8'h02, got);
            sleep_mode <= 1'b0;
            rchk(4'h0, 8'h05);
            wr(4'h4, 8'h01);
        end
        // ==========================================================
        // reset in mid-conversion
        conv(3'b110, 1'b1, 1'b1, 5'h02, 10'h2aa);
        repeat (20) @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        check("reset", 8'h00, {6'h00, analog_power, sample_hold});
        rchk(4'h0, 8'h00);
        rchk(4'h1, 8'h00);
        close_out;
    end
endmodule // adcseq_tb_top

/* verilog/adcseq_top.v */
/*
 * control and sequencing of a 10-bit successive-approximation converter:
 * register port, go/done handling, abort, justification, sleep and trigger.
 * assumes an external comparator answering each trial within the same
 * half-period, and synchronous inputs on clk_sys.
 */
// Added by the designer: the address-and-strobe port and the register addresses.
// Operation
// - justify select picks left or right layout
// - runs only when enabled; go starts
// - finish clears go, sets flag, loads result
// - clearing go aborts; fill with last bit
// - reset clears registers, stops conversion
// - sleep conversion only on RC, extra delay; the code's RC delay state adds none, the tick divider runs through it
// - sleep end wakes or powers down
// - sleep on other clock aborts, powers down
// - trigger sets go, clears first timer; code clears it only while idle
// - channel field bits 6-2, bit 7 zero
// - temperature, dac and reference channel codes
// - go reads one while converting
// - enable bit powers converter
// - left layout: high holds 9-2
// - conversion lasts 11.5 bit periods
`timescale 1ns/10ps
`include "adcseq_regs.vh"

module adcseq_top #(
    parameter DIV_DEFAULT = `ADCSEQ_DIV_DEFAULT,
    parameter RC_DIV      = 13
) (
    input  wire       clk_sys,
    input  wire       reset,
    input  wire [3:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       sleep_mode,
    input  wire       special_trigger,
    input  wire       comparator_high,
    output reg        analog_power,
    output reg  [4:0] input_channel_select,
    output reg  [9:0] trial_code,
    output reg        sample_hold,
    output reg        first_timer_clear,
    output reg        conversion_done_irq_flag,
    output reg        wake_request
);

    // ==========================================================
    // state
    localparam ST_IDLE  = 2'h0;
    localparam ST_DELAY = 2'h1;
    localparam ST_CONV  = 2'h2;
    // rc half-period length at register width
    localparam [7:0] RC_HALF = RC_DIV;

    reg [1:0] state;
    reg       converter_enable_bit;
    reg       go_flag;
    reg       irq_enable;
    reg [2:0] clk_select;
    reg       result_justify_select;
    reg [7:0] result_high_reg;
    reg [7:0] result_low_reg;
    reg [9:0] sar;
    reg [3:0] bit_idx;
    reg [4:0] half_cnt;
    reg [7:0] div_cnt;
    reg [2:0] delay_cnt;
    reg       slept_off;
    reg       last_bit;
    reg       tick;

    wire clk_is_rc = (clk_select[1:0] == `ADCSEQ_CLK_RC);
    wire ctl_wr    = reg_wr && (reg_addr == `ADCSEQ_OFS_CONTROL);
    wire go_clear  = ctl_wr && !reg_wdata[`ADCSEQ_CTL_GO];
    wire go_set    = ctl_wr && reg_wdata[`ADCSEQ_CTL_GO];
    wire running   = (state != ST_IDLE);

    // half-period length in system clocks for the selected clock
    function [7:0] half_len;
        input [2:0] sel;
        begin
            case (sel)
                3'h0:    half_len = 8'h01;
                3'h4:    half_len = 8'h02;
                3'h1:    half_len = 8'h04;
                3'h5:    half_len = 8'h08;
                3'h2:    half_len = 8'h10;
                3'h6:    half_len = 8'h20;
                default: half_len = RC_HALF;
            endcase
        end
    endfunction

    // fill unresolved positions at and below idx with the last resolved bit
    function [9:0] fill_partial;
        input [9:0] val;
        input [3:0] idx;
        input       fill;
        integer i;
        begin
            fill_partial = val;
            for (i = 0; i < `ADCSEQ_BITS; i = i + 1) begin
                if (i <= idx)
                    fill_partial[i] = fill;
            end
        end
    endfunction

    // ==========================================================
    // half-period tick divider
    always @(posedge clk_sys) begin
        if (reset || !running) begin
            div_cnt <= 8'h00;
            tick    <= 1'b0;
        end else if (div_cnt + 8'h01 >= half_len(clk_select)) begin
            div_cnt <= 8'h00;
            tick    <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 8'h01;
            tick    <= 1'b0;
        end
    end

    // ==========================================================
    // registers and sequencer
    always @(posedge clk_sys) begin
        if (reset) begin
            state                    <= ST_IDLE;
            converter_enable_bit     <= 1'b0;
            go_flag                  <= 1'b0;
            input_channel_select     <= 5'h00;
            irq_enable               <= 1'b0;
            clk_select               <= 3'h0;
            result_justify_select    <= 1'b0;
            result_high_reg          <= 8'h00;
            result_low_reg           <= 8'h00;
            sar                      <= 10'h000;
            bit_idx                  <= 4'h0;
            half_cnt                 <= 5'h00;
            delay_cnt                <= 3'h0;
            slept_off                <= 1'b0;
            last_bit                 <= 1'b0;
            conversion_done_irq_flag <= 1'b0;
            first_timer_clear        <= 1'b0;
            wake_request             <= 1'b0;
        end else begin
            first_timer_clear <= 1'b0;
            wake_request      <= 1'b0;
            if (ctl_wr) begin
                converter_enable_bit <= reg_wdata[`ADCSEQ_CTL_ENABLE];
                input_channel_select <= reg_wdata[`ADCSEQ_CTL_CHS_HI:`ADCSEQ_CTL_CHS_LO];
                if (!reg_wdata[`ADCSEQ_CTL_ENABLE])
                    slept_off <= 1'b0;
            end
            if (reg_wr && reg_addr == `ADCSEQ_OFS_CONFIG) begin
                irq_enable            <= reg_wdata[`ADCSEQ_CFG_IRQ_EN];
                clk_select            <= reg_wdata[`ADCSEQ_CFG_CLK_HI:`ADCSEQ_CFG_CLK_LO];
                result_justify_select <= reg_wdata[`ADCSEQ_CFG_JUSTIFY];
            end
            if (reg_wr && reg_addr == `ADCSEQ_OFS_STATUS &&
                reg_wdata[`ADCSEQ_STS_DONE_FLAG])
                conversion_done_irq_flag <= 1'b0;
            if (!sleep_mode)
                slept_off <= 1'b0;
            case (state)
                ST_IDLE: begin
                    // enable must already be on; go while off is ignored
                    if (converter_enable_bit && !slept_off &&
                        (go_set || special_trigger)) begin
                        go_flag   <= 1'b1;
                        sar       <= 10'h200;
                        bit_idx   <= 4'h9;
                        half_cnt  <= 5'h00;
                        delay_cnt <= 3'h0;
                        state     <= clk_is_rc ? ST_DELAY : ST_CONV;
                    end
                    if (special_trigger)
                        first_timer_clear <= 1'b1;
                end
                ST_DELAY: begin
                    if (go_clear || !converter_enable_bit) begin
                        go_flag <= 1'b0;
                        state   <= ST_IDLE;
                    end else if (delay_cnt == `ADCSEQ_RC_DELAY_CYC - 1) begin
                        state <= ST_CONV;
                    end else begin
                        delay_cnt <= delay_cnt + 3'h1;
                    end
                end
                ST_CONV: begin
                    // disabling mid-conversion stops it like an abort
                    if (go_clear || !converter_enable_bit ||
                        (sleep_mode && !clk_is_rc)) begin
                        go_flag         <= 1'b0;
                        state           <= ST_IDLE;
                        slept_off       <= sleep_mode;
                        {result_high_reg, result_low_reg} <=
                            justify(fill_partial(sar, bit_idx, last_bit),
                                    result_justify_select);
                    end else if (tick) begin
                        half_cnt <= half_cnt + 5'h01;
                        // two half periods before the first bit, then two per bit
                        if (half_cnt[0] && half_cnt != 5'h01 && bit_idx != 4'hf) begin
                            sar[bit_idx] <= comparator_high;
                            last_bit     <= comparator_high;
                            if (bit_idx != 4'h0)
                                sar[bit_idx - 4'h1] <= 1'b1;
                            bit_idx <= bit_idx - 4'h1;
                        end
                        if (half_cnt == `ADCSEQ_HALF_PERIODS - 1) begin
                            go_flag                  <= 1'b0;
                            conversion_done_irq_flag <= 1'b1;
                            {result_high_reg, result_low_reg} <=
                                justify(sar, result_justify_select);
                            state <= ST_IDLE;
                            if (sleep_mode) begin
                                wake_request <= irq_enable;
                                slept_off    <= !irq_enable;
                            end
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // left: high = 9..2, low top = 1..0; right: high low bits = 9..8
    function [15:0] justify;
        input [9:0] val;
        input       right;
        begin
            if (right)
                justify = {6'h00, val[9:8], val[7:0]};
            else
                justify = {val[9:2], val[1:0], 6'h00};
        end
    endfunction

    // ==========================================================
    // analog side outputs
    always @(posedge clk_sys) begin
        if (reset) begin
            analog_power <= 1'b0;
            trial_code   <= 10'h000;
            sample_hold  <= 1'b0;
        end else begin
            analog_power <= converter_enable_bit && !slept_off &&
                            !(sleep_mode && !clk_is_rc && !running);
            trial_code   <= sar;
            sample_hold  <= (state == ST_CONV) && (half_cnt != 5'h00);
        end
    end

    // ==========================================================
    // read port, data one cycle after the strobe
    always @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `ADCSEQ_OFS_CONTROL:  reg_rdata <= {1'b0, input_channel_select, go_flag,
                                                    converter_enable_bit};
                `ADCSEQ_OFS_CONFIG:   reg_rdata <= {result_justify_select, clk_select,
                                                    3'h0, irq_enable};
                `ADCSEQ_OFS_RES_HIGH: reg_rdata <= result_high_reg;
                `ADCSEQ_OFS_RES_LOW:  reg_rdata <= result_low_reg;
                `ADCSEQ_OFS_STATUS:   reg_rdata <= {5'h00, wake_request, analog_power,
                                                    conversion_done_irq_flag};
                default:              reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // adcseq_top
